// *** design/cs_pkg.sv ***
/*
  Shared constants for the capacitive sense range and timebase block:
  register offsets, field positions, reset values, oscillator modes.
  Assumes a plain byte-addressed register port with 16-bit data.
*/
package cs_pkg;

  // Register port widths
  localparam int AW = 5;                          // Byte address width
  localparam int DW = 16;                         // Read/write data width

  // Register byte offsets
  localparam logic [AW-1:0] OFS_CTRL0   = 5'h00; // Sense control zero
  localparam logic [AW-1:0] OFS_CTRL1   = 5'h04; // Channel select
  localparam logic [AW-1:0] OFS_TA_CFG  = 5'h08; // Timer A clock source
  localparam logic [AW-1:0] OFS_TA_CNT  = 5'h0C; // Timer A count
  localparam logic [AW-1:0] OFS_TB_CTRL = 5'h10; // Timer B control
  localparam logic [AW-1:0] OFS_TB_CNT  = 5'h14; // Timer B count
  localparam logic [AW-1:0] OFS_STATUS  = 5'h18; // Sticky flags, write 1 clears
  localparam logic [AW-1:0] OFS_MODE    = 5'h1C; // Decoded oscillator mode

  // Sense control zero fields
  localparam int CTRL0_EN   = 7;                  // Module enable
  localparam int CTRL0_REF  = 6;                  // Reference range select
  localparam int CTRL0_RNG  = 2;                  // Current range field, 2 bits
  localparam int CTRL0_DIR  = 1;                  // Oscillator direction, read only
  localparam int CTRL0_XSEL = 0;                  // Timer A external source select

  // Timer B control fields
  localparam int TB_CS      = 6;                  // Clock source, 2 bits
  localparam int TB_GTOG    = 3;                  // Gate toggle mode
  localparam int TB_GSRC    = 2;                  // Gate source in toggle mode: 0 pin, 1 timer A overflow
  localparam int TB_GE      = 1;                  // Gate enable
  localparam int TB_RUN     = 0;                  // Run

  // Status fields
  localparam int ST_TA_OVF  = 0;                  // Timer A overflow
  localparam int ST_NOISE   = 1;                  // Activity seen in noise mode

  // Codes
  localparam logic [1:0] RNG_OFF    = 2'h0;       // Off or noise detection
  localparam logic [1:0] RNG_LOW    = 2'h1;
  localparam logic [1:0] RNG_MED    = 2'h2;
  localparam logic [1:0] RNG_HIGH   = 2'h3;
  localparam logic [1:0] TB_CS_SYS4 = 2'h0;       // System clock over four
  localparam logic [1:0] TB_CS_SYS  = 2'h1;       // System clock
  localparam logic [1:0] TB_CS_PIN  = 2'h2;       // External count pin
  localparam logic [1:0] TB_CS_OSC  = 2'h3;       // Sensing oscillator
  localparam logic [3:0] CHAN_LAST  = 4'hB;       // Highest legal channel
  localparam logic [1:0] DIV4_LAST  = 2'h3;       // Divider terminal count

  // Reset values
  localparam logic [DW-1:0] RST_ZERO = 16'h0000;

  // Oscillator power modes plus off
  typedef enum logic [2:0] {
    CS_OFF, CS_NOISE, CS_FIX_LOW, CS_FIX_MED, CS_FIX_HIGH,
    CS_VAR_LOW, CS_VAR_MED, CS_VAR_HIGH
  } cs_mode_t;

endpackage : cs_pkg

// *** design/cs_sync.sv ***
/*
  Three-stage synchroniser with agreement filter for one asynchronous input.
  Assumes a single system clock; outputs a filtered level and a rise pulse.
*/
`timescale 1ns/1ps
module cs_sync (
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic async_in,
  output logic      level,
  output logic      rise
);
  logic s1_r;                                     // Metastable stage, read only by s2
  logic s2_r;
  logic s3_r;
  logic lvl_r;                                    // Filtered level
  logic lvl_nxt;

  // A change counts once stages two and three agree
  assign lvl_nxt = (s2_r == s3_r) ? s3_r : lvl_r;

  // Sync chain and filter
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      s1_r  <= 1'b0;
      s2_r  <= 1'b0;
      s3_r  <= 1'b0;
      lvl_r <= 1'b0;
      rise  <= 1'b0;
    end else begin
      s1_r  <= async_in;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      lvl_r <= lvl_nxt;
      rise  <= lvl_nxt & ~lvl_r;
    end
  end

  assign level = lvl_r;
endmodule : cs_sync

// *** design/cs_range_timebase.sv ***
/*
  Capacitive sense control: range/mode decode, channel select, oscillator
  routing into two timers, timer B run/gate logic, register port.
  Assumes the analog oscillator, references and pad mux sit outside and
  that software does the frequency arithmetic with the timer counts.
*/
// Local design decisions: the register offsets and the address-and-strobe port.
// What this block does
// - Reference bit picks fixed or variable thresholds
// - Seven oscillator power modes in two ranges
// - Range field picks low, medium, high, off/noise
// - Noise mode stops pin current, oscillator stays on
// - Noise on pin toggles comparator, activity detected
// - Oscillator clocks the chosen timer resource
// - Source select set, clock bit clear: oscillator clocks A
// - Timer B source 11 uses oscillator
// - Timer B off, free run, or gated
// - Enable bit seven switches module on/off
// - Disabled module ignores channel field
// - Direction flag one sourcing, zero sinking
`timescale 1ns/1ps
module cs_range_timebase #(
  parameter int TA_W = 8,                         // Timer A width
  parameter int TB_W = 16                         // Timer B width
) (
  input  wire logic                 mclk,
  input  wire logic                 rst_b,
  input  wire logic [cs_pkg::AW-1:0] addr,
  input  wire logic [cs_pkg::DW-1:0] wdata,
  input  wire logic                 wr_en,
  input  wire logic                 rd_en,
  output logic      [cs_pkg::DW-1:0] rdata,
  input  wire logic                 osc_out,      // Comparator output, asynchronous
  input  wire logic                 count_pin_a,  // External count pin, asynchronous
  input  wire logic                 gate_pin_b,   // Timer B gate pin, asynchronous
  output cs_pkg::cs_mode_t          osc_mode,
  output logic                      use_var_refs,
  output logic      [1:0]           current_level,
  output logic                      pin_current_en,
  output logic                      osc_run,
  output logic      [3:0]           sense_chan,
  output logic                      sense_chan_valid
);
  import cs_pkg::*;

  // Software-written state
  logic            sense_enable_r;                // Module on
  logic            ref_range_select_r;            // Variable references
  logic [1:0]      current_range_field_r;
  logic            timer_a_ext_source_sel_r;
  logic            timer_a_clock_source_r;        // 0 system clock over four
  logic [3:0]      sense_channel_sel_r;
  logic [1:0]      timer_b_clock_source_r;
  logic            timer_b_gate_toggle_r;
  logic            timer_b_gate_src_r;
  logic            timer_b_gate_en_r;
  logic            timer_b_run_r;
  // Hardware state
  logic [TA_W-1:0] tmr_a_r;
  logic [TA_W-1:0] tmr_a_nxt;
  logic [TB_W-1:0] tmr_b_r;
  logic [TB_W-1:0] tmr_b_nxt;
  logic            ta_ovf_r;                      // Sticky overflow flag
  logic            noise_act_r;                   // Sticky noise activity flag
  logic            osc_direction_flag_r;
  logic            gate_tog_r;                    // Toggle-mode gate state
  logic [1:0]      div4_r;                        // System clock over four
  cs_mode_t        mode_nxt;

  // Synchronised inputs
  logic osc_lvl, osc_rise, pin_a_rise, gate_lvl, gate_rise;

  // Oscillator output is never used raw
  cs_sync u_sync_osc (.mclk(mclk), .rst_b(rst_b), .async_in(osc_out),
                      .level(osc_lvl), .rise(osc_rise));
  cs_sync u_sync_pa  (.mclk(mclk), .rst_b(rst_b), .async_in(count_pin_a),
                      .level(), .rise(pin_a_rise));
  cs_sync u_sync_gb  (.mclk(mclk), .rst_b(rst_b), .async_in(gate_pin_b),
                      .level(gate_lvl), .rise(gate_rise));

  // Register decode
  wire wr_ctrl0 = wr_en && (addr == OFS_CTRL0);
  wire wr_ctrl1 = wr_en && (addr == OFS_CTRL1);
  wire wr_tacfg = wr_en && (addr == OFS_TA_CFG);
  wire wr_tacnt = wr_en && (addr == OFS_TA_CNT);
  wire wr_tbctl = wr_en && (addr == OFS_TB_CTRL);
  wire wr_tbcnt = wr_en && (addr == OFS_TB_CNT);
  wire wr_stat  = wr_en && (addr == OFS_STATUS);

  // Mode decode from reference bit and range field
  always_comb begin
    mode_nxt = CS_OFF;                            // Disabled or fixed-range 00
    if (sense_enable_r) begin
      unique case ({ref_range_select_r, current_range_field_r})
        {1'b0, RNG_OFF}:  mode_nxt = CS_OFF;
        {1'b0, RNG_LOW}:  mode_nxt = CS_FIX_LOW;
        {1'b0, RNG_MED}:  mode_nxt = CS_FIX_MED;
        {1'b0, RNG_HIGH}: mode_nxt = CS_FIX_HIGH;
        {1'b1, RNG_OFF}:  mode_nxt = CS_NOISE;
        {1'b1, RNG_LOW}:  mode_nxt = CS_VAR_LOW;
        {1'b1, RNG_MED}:  mode_nxt = CS_VAR_MED;
        {1'b1, RNG_HIGH}: mode_nxt = CS_VAR_HIGH;
      endcase
    end
  end

  // Divider for the slow system tick
  wire sys4_tick = (div4_r == DIV4_LAST);

  // Timer A clock: source select wins, so the oscillator feeds it with the
  // clock source bit clear or set; otherwise pin or system over four
  wire ta_tick = timer_a_ext_source_sel_r ? osc_rise :
                 (timer_a_clock_source_r ? pin_a_rise : sys4_tick);
  wire ta_wrap = ta_tick && (tmr_a_r == {TA_W{1'b1}});

  // Timer B clock source select
  wire tb_src_tick = (timer_b_clock_source_r == TB_CS_OSC)  ? osc_rise :
                     (timer_b_clock_source_r == TB_CS_PIN)  ? pin_a_rise :
                     (timer_b_clock_source_r == TB_CS_SYS)  ? 1'b1 : sys4_tick;
  // Gate event for toggle mode: pin rise or timer A overflow
  wire gate_evt    = timer_b_gate_src_r ? ta_wrap : gate_rise;
  wire gate_open   = timer_b_gate_toggle_r ? gate_tog_r : gate_lvl;
  // Off, free running, or counting while gate open
  wire tb_tick     = timer_b_run_r && (!timer_b_gate_en_r || gate_open) && tb_src_tick;

  // Count updates; a software write to a count wins over a tick
  assign tmr_a_nxt = wr_tacnt ? wdata[TA_W-1:0] :
                     ta_tick  ? tmr_a_r + 1'b1 : tmr_a_r;
  assign tmr_b_nxt = wr_tbcnt ? wdata[TB_W-1:0] :
                     tb_tick  ? tmr_b_r + 1'b1 : tmr_b_r;

  // Control registers
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      sense_enable_r           <= 1'b0;
      ref_range_select_r       <= 1'b0;
      current_range_field_r    <= RNG_OFF;
      timer_a_ext_source_sel_r <= 1'b0;
      timer_a_clock_source_r   <= 1'b0;
      sense_channel_sel_r      <= 4'h0;
      timer_b_clock_source_r   <= TB_CS_SYS4;
      timer_b_gate_toggle_r    <= 1'b0;
      timer_b_gate_src_r       <= 1'b0;
      timer_b_gate_en_r        <= 1'b0;
      timer_b_run_r            <= 1'b0;
    end else begin
      if (wr_ctrl0) begin
        sense_enable_r           <= wdata[CTRL0_EN];
        ref_range_select_r       <= wdata[CTRL0_REF];
        current_range_field_r    <= wdata[CTRL0_RNG +: 2];
        timer_a_ext_source_sel_r <= wdata[CTRL0_XSEL];
      end
      if (wr_ctrl1) sense_channel_sel_r    <= wdata[3:0];
      if (wr_tacfg) timer_a_clock_source_r <= wdata[0];
      if (wr_tbctl) begin
        timer_b_clock_source_r <= wdata[TB_CS +: 2];
        timer_b_gate_toggle_r  <= wdata[TB_GTOG];
        timer_b_gate_src_r     <= wdata[TB_GSRC];
        timer_b_gate_en_r      <= wdata[TB_GE];
        timer_b_run_r          <= wdata[TB_RUN];
      end
    end
  end

  // Timers, flags, divider
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      tmr_a_r     <= '0;
      tmr_b_r     <= '0;
      ta_ovf_r    <= 1'b0;
      noise_act_r <= 1'b0;
      gate_tog_r  <= 1'b0;
      div4_r      <= 2'h0;
    end else begin
      tmr_a_r  <= tmr_a_nxt;
      tmr_b_r  <= tmr_b_nxt;
      div4_r   <= div4_r + 2'h1;
      // Set beats a same-cycle write-one clear
      ta_ovf_r <= ta_wrap || (ta_ovf_r && !(wr_stat && wdata[ST_TA_OVF]));
      noise_act_r <= (osc_rise && mode_nxt == CS_NOISE) ||
                     (noise_act_r && !(wr_stat && wdata[ST_NOISE]));
      // Toggle state restarts closed when toggle mode is off
      if (!timer_b_gate_toggle_r) gate_tog_r <= 1'b0;
      else if (gate_evt)          gate_tog_r <= ~gate_tog_r;
    end
  end

  // Analog-facing outputs, all registered
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      osc_mode             <= CS_OFF;
      use_var_refs         <= 1'b0;
      current_level        <= RNG_OFF;
      pin_current_en       <= 1'b0;
      osc_run              <= 1'b0;
      sense_chan           <= 4'h0;
      sense_chan_valid     <= 1'b0;
      osc_direction_flag_r <= 1'b0;
    end else begin
      osc_mode       <= mode_nxt;
      use_var_refs   <= sense_enable_r && ref_range_select_r;
      current_level  <= sense_enable_r ? current_range_field_r : RNG_OFF;
      // Noise mode keeps comparators alive but sources no current
      osc_run        <= (mode_nxt != CS_OFF);
      pin_current_en <= (mode_nxt != CS_OFF) && (mode_nxt != CS_NOISE);
      // Reserved codes select nothing rather than alias a channel
      sense_chan       <= sense_enable_r ? sense_channel_sel_r : 4'h0;
      sense_chan_valid <= sense_enable_r && (sense_channel_sel_r <= CHAN_LAST);
      // High while sourcing; comparator high means charging phase
      osc_direction_flag_r <= sense_enable_r && osc_lvl;
    end
  end

  // Read mux, unmapped reads give zero
  logic [DW-1:0] rd_mux;
  always_comb begin
    rd_mux = RST_ZERO;
    unique case (addr)
      OFS_CTRL0:   rd_mux = DW'({sense_enable_r, ref_range_select_r, 2'b00,
                                 current_range_field_r, osc_direction_flag_r,
                                 timer_a_ext_source_sel_r});
      OFS_CTRL1:   rd_mux = DW'(sense_channel_sel_r);
      OFS_TA_CFG:  rd_mux = DW'(timer_a_clock_source_r);
      OFS_TA_CNT:  rd_mux = DW'(tmr_a_r);
      OFS_TB_CTRL: rd_mux = DW'({timer_b_clock_source_r, 2'b00, timer_b_gate_toggle_r,
                                 timer_b_gate_src_r, timer_b_gate_en_r, timer_b_run_r});
      OFS_TB_CNT:  rd_mux = DW'(tmr_b_r);
      OFS_STATUS:  rd_mux = DW'({noise_act_r, ta_ovf_r});
      OFS_MODE:    rd_mux = DW'(osc_mode);
      default:     rd_mux = RST_ZERO;
    endcase
  end

  // Read data stand in the cycle after the strobe only
  always_ff @(posedge mclk) begin
    if (!rst_b) rdata <= RST_ZERO;
    else        rdata <= rd_en ? rd_mux : RST_ZERO;
  end

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  property p_ref_range;
    osc_mode != CS_OFF && osc_mode != CS_NOISE |->
      use_var_refs == (osc_mode inside {CS_VAR_LOW, CS_VAR_MED, CS_VAR_HIGH});
  endproperty
  a_ref_range: assert property (p_ref_range) else $error("reference select mismatch");

  property p_off_decode;
    ##1 (osc_mode == CS_OFF) ==
        $past(!sense_enable_r || (!ref_range_select_r && current_range_field_r == RNG_OFF));
  endproperty
  a_off_decode: assert property (p_off_decode) else $error("off decode wrong");

  property p_seven_modes;
    osc_run |-> osc_mode != CS_OFF && current_level == (osc_mode == CS_NOISE ? RNG_OFF :
      (osc_mode inside {CS_FIX_LOW, CS_VAR_LOW}) ? RNG_LOW :
      (osc_mode inside {CS_FIX_MED, CS_VAR_MED}) ? RNG_MED : RNG_HIGH);
  endproperty
  a_seven_modes: assert property (p_seven_modes) else $error("mode and level disagree");

  property p_noise_no_current;
    osc_mode == CS_NOISE |-> osc_run && !pin_current_en;
  endproperty
  a_noise_no_current: assert property (p_noise_no_current) else $error("current in noise mode");

  property p_noise_activity;
    osc_rise && mode_nxt == CS_NOISE |=> noise_act_r;
  endproperty
  a_noise_activity: assert property (p_noise_activity) else $error("noise activity missed");

  property p_ta_osc_count;
    timer_a_ext_source_sel_r && osc_rise && !wr_tacnt
      |=> tmr_a_r == TA_W'($past(tmr_a_r) + 1'b1);
  endproperty
  a_ta_osc_count: assert property (p_ta_osc_count) else $error("timer A missed osc edge");

  property p_tb_osc_count;
    timer_b_clock_source_r == TB_CS_OSC && timer_b_run_r && !timer_b_gate_en_r &&
      osc_rise && !wr_tbcnt |=> tmr_b_r == TB_W'($past(tmr_b_r) + 1'b1);
  endproperty
  a_tb_osc_count: assert property (p_tb_osc_count) else $error("timer B missed osc edge");

  property p_tb_off;
    (!timer_b_run_r || (timer_b_gate_en_r && !gate_open)) && !wr_tbcnt |=> $stable(tmr_b_r);
  endproperty
  a_tb_off: assert property (p_tb_off) else $error("timer B counted while off");

  property p_disabled_no_chan;
    !sense_enable_r ##1 !sense_enable_r |-> !sense_chan_valid && !osc_run;
  endproperty
  a_disabled_no_chan: assert property (p_disabled_no_chan) else $error("channel while disabled");

  property p_dir_flag;
    sense_enable_r && $stable(sense_enable_r) |=> osc_direction_flag_r == $past(osc_lvl);
  endproperty
  a_dir_flag: assert property (p_dir_flag) else $error("direction flag wrong");

  property p_osc_synced;
    osc_rise |-> osc_lvl && !$past(osc_lvl);
  endproperty
  a_osc_synced: assert property (p_osc_synced) else $error("rise without level change");

  c_noise_mode: cover property (osc_mode == CS_NOISE ##1 noise_act_r);
  c_tb_gated:   cover property (timer_b_gate_toggle_r && gate_evt ##1 gate_tog_r ##1 tb_tick);
  c_ta_wrap:    cover property (ta_wrap && timer_a_ext_source_sel_r ##1 ta_ovf_r);
  c_var_high:   cover property (osc_mode == CS_VAR_HIGH && use_var_refs);
endmodule : cs_range_timebase

// *** testbench/cs_osc_model.sv ***
/*
  Behavioural sensing oscillator and pad: a square stand-in for the
  comparator output of the triangle oscillator.
  Assumes the block's power and pin-current outputs steer it directly.
*/
`timescale 1ns/1ps
module cs_osc_model #(
  parameter int HALF = 8              // Half period in clock cycles
) (
  input  wire logic mclk,
  input  wire logic run,             // Oscillator powered
  input  wire logic drive,           // Pin current sourced and sunk
  input  wire logic noise,           // Pad disturbance, noise mode only
  input  wire logic load,            // Touch load on the pad, slows the ramp
  output logic      osc_out          // High while sourcing
);
  int   cnt_r;                       // Phase counter
  logic tri_r = 1'b0;                // Charge phase, 1 = sourcing
  int   lim;                         // Ramp length for this pad load
  assign lim = load ? HALF + HALF / 2 : HALF;
  // Ramp only while current flows; stalled phase keeps its level
  always_ff @(posedge mclk) begin
    if (!(run && drive)) begin
      cnt_r <= 0;                    // No current, no ramp
    end else if (cnt_r >= lim - 1) begin  // At or past, so a load change never stalls it
      cnt_r <= 0;
      tri_r <= ~tri_r;               // Threshold reached
    end else begin
      cnt_r <= cnt_r + 1;
    end
  end
  // Unpowered comparator sits low; in noise mode the pad alone moves it
  assign osc_out = !run ? 1'b0 : (drive ? tri_r : noise);
endmodule : cs_osc_model

// *** testbench/cs_range_timebase_bench.sv ***
/*
  Self-checking bench: mode decode, channel select, timer routing,
  gating, overflow time base and noise detection through the registers.
  Assumes the oscillator model above sits on the sensing side.
*/
`timescale 1ns/1ps
module cs_range_timebase_bench;
  import cs_pkg::*;
  localparam int HALF = 8;                 // Oscillator half period
  logic          mclk = 1'b0;
  logic          rst_b;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata, d;
  logic          wr_en, rd_en, osc_out, count_pin_a, gate_pin_b, noise;
  cs_mode_t      osc_mode;
  logic          use_var_refs, pin_current_en, osc_run, sense_chan_valid;
  logic [1:0]    current_level;
  logic [3:0]    sense_chan, ch;
  logic          en;
  logic          pad_load;                 // Touch load on the pad
  logic [DW-1:0] d_rd;                     // Raw read data
  logic [DW-1:0] cw, nom, thr;             // Control word, nominal count, touch threshold
  int            err_total = 0, n_tests = 0, cyc = 0, i;
  cs_range_timebase dut (.mclk(mclk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(d_rd), .osc_out(osc_out),
    .count_pin_a(count_pin_a), .gate_pin_b(gate_pin_b), .osc_mode(osc_mode),
    .use_var_refs(use_var_refs), .current_level(current_level),
    .pin_current_en(pin_current_en), .osc_run(osc_run), .sense_chan(sense_chan),
    .sense_chan_valid(sense_chan_valid));
  cs_osc_model #(.HALF(HALF)) osc (.mclk(mclk), .run(osc_run), .drive(pin_current_en),
    .noise(noise), .load(pad_load), .osc_out(osc_out));
  // 100 MHz clock
  initial begin
    forever #5 mclk = ~mclk;
  end
  // Hang guard, well above the planned run
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_total = err_total + 1;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // One-cycle write strobe
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] v);
    @(posedge mclk);
    addr  <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] v);
    @(posedge mclk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1 v = d_rd;
  endtask : rd
  // Expected decode of enable, reference bit and range field
  function automatic cs_mode_t exp_mode(input logic e, input logic r, input logic [1:0] g);
    if (!e) return CS_OFF;
    if (r) return (g == RNG_OFF) ? CS_NOISE : cs_mode_t'(3'(CS_VAR_LOW) + 3'(g) - 3'h1);
    return (g == RNG_OFF) ? CS_OFF : cs_mode_t'(3'(CS_FIX_LOW) + 3'(g) - 3'h1);
  endfunction : exp_mode
  // Counts carry sync skew, so a small tolerance
  function automatic logic near(input logic [15:0] v, input logic [15:0] e);
    return (v + 16'h0004 >= e) && (v <= e + 16'h0004);
  endfunction : near
  // Clear a counter, wait a window, read it back
  task automatic meas(input logic [AW-1:0] a, input int win, output logic [DW-1:0] v);
    wr(a, 16'h0000);
    repeat (win) @(posedge mclk);
    rd(a, v);
  endtask : meas
  initial begin
    rst_b = 1'b0; addr = '0; wdata = '0; wr_en = 1'b0; rd_en = 1'b0;
    count_pin_a = 1'b0; gate_pin_b = 1'b0; noise = 1'b0; pad_load = 1'b0;
    void'($urandom(32'h7b30));
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    // Reset values, then an unmapped place that ignores writes
    for (i = 0; i < 8; i++) begin
      rd(5'(i * 4), d);
      // Timer A runs on sysclk over four from reset; read edge is 2i+2 after release
      chk("reset value", d, (i == 3) ? 16'((2 * i + 1) / (int'(DIV4_LAST) + 1)) : RST_ZERO);
    end
    wr(5'h1E, 16'hFFFF);
    rd(5'h1E, d);
    chk("unmapped", d, 16'h0000);
    // Every enable, reference and range combination
    for (i = 0; i < 16; i++) begin
      cw = {8'h00, i[3], i[2], 2'b00, i[1:0], 2'b00};
      wr(OFS_CTRL0, cw);
      repeat (2) @(posedge mclk);
      #1;
      chk("osc_mode", 16'(osc_mode), 16'(exp_mode(i[3], i[2], i[1:0])));
      chk("pin_current_en", 16'(pin_current_en), 16'(i[3] && i[1:0] != 2'b00));
      chk("osc_run", 16'(osc_run), 16'(exp_mode(i[3], i[2], i[1:0]) != CS_OFF));
      chk("current_level", 16'(current_level), i[3] ? 16'(i[1:0]) : 16'h0);
      if (i[3]) chk("use_var_refs", 16'(use_var_refs), 16'(i[2]));
      rd(OFS_MODE, d);
      chk("mode reg", d, 16'(exp_mode(i[3], i[2], i[1:0])));
      rd(OFS_CTRL0, d);
      chk("ctrl0", d & 16'h00FD, cw);
    end
    // Channel codes: last legal, first reserved, top, then random
    for (i = 0; i < 20; i++) begin
      ch = (i == 0) ? CHAN_LAST : (i == 1) ? 4'hC : (i == 2) ? 4'hF : 4'($urandom_range(15));
      en = (i < 3) ? 1'b1 : 1'($urandom_range(1));
      wr(OFS_CTRL0, {8'h00, en, 7'h00});
      wr(OFS_CTRL1, {12'h000, ch});
      repeat (2) @(posedge mclk);
      #1;
      chk("sense_chan", 16'(sense_chan), en ? 16'(ch) : 16'h0);
      chk("chan_valid", 16'(sense_chan_valid), 16'(en && ch <= CHAN_LAST));
    end
    // Variable high range, oscillator running
    wr(OFS_CTRL0, 16'h00CC);
    repeat (40) @(posedge mclk);
    wr(OFS_TB_CTRL, 16'h00C1);
    meas(OFS_TB_CNT, 640, d);
    chk("tb osc count", 16'(near(d, 16'(640 / (2 * HALF)))), 16'h1);
    // Loaded pad, same window: slower count, threshold between the two
    nom = d;
    @(posedge mclk) pad_load <= 1'b1;
    meas(OFS_TB_CNT, 640, d);
    chk("tb loaded count", 16'(near(d, 16'(640 / (3 * HALF)))), 16'h1);
    thr = (nom + d) >> 1;
    chk("loaded below nominal", 16'(d < nom), 16'h1);
    chk("threshold split", 16'(d < thr && thr < nom), 16'h1);
    @(posedge mclk) pad_load <= 1'b0;
    wr(OFS_TB_CTRL, 16'h0081);
    meas(OFS_TB_CNT, 640, d);
    chk("tb pin count", d, 16'h0000);
    wr(OFS_TB_CTRL, 16'h0041);
    meas(OFS_TB_CNT, 640, d);
    chk("tb sys count", 16'(near(d, 16'd642)), 16'h1);
    wr(OFS_TB_CTRL, 16'h00C0);
    meas(OFS_TB_CNT, 640, d);
    chk("tb off", d, 16'h0000);
    wr(OFS_TB_CTRL, 16'h00C3);
    meas(OFS_TB_CNT, 640, d);
    chk("tb gate closed", d, 16'h0000);
    @(posedge mclk) gate_pin_b <= 1'b1;
    meas(OFS_TB_CNT, 640, d);
    chk("tb gate open", 16'(near(d, 16'(640 / (2 * HALF)))), 16'h1);
    // Timer A from the oscillator, clock source bit clear then set, then idle pin
    wr(OFS_CTRL0, 16'h00CD);
    meas(OFS_TA_CNT, 640, d);
    chk("ta osc count", 16'(near(d, 16'(640 / (2 * HALF)))), 16'h1);
    wr(OFS_TA_CFG, 16'h0001);
    meas(OFS_TA_CNT, 640, d);
    chk("ta osc count cs set", 16'(near(d, 16'(640 / (2 * HALF)))), 16'h1);
    wr(OFS_CTRL0, 16'h00CC);
    meas(OFS_TA_CNT, 640, d);
    chk("ta pin count", d, 16'h0000);
    // Time base: timer A overflow toggling the gate of timer B
    wr(OFS_TA_CFG, 16'h0000);
    wr(OFS_TB_CTRL, 16'h00CF);
    wr(OFS_STATUS, 16'h0003);
    wr(OFS_TA_CNT, 16'h0000);
    meas(OFS_TB_CNT, 2300, d);
    chk("toggle window", 16'(near(d, 16'(1024 / (2 * HALF)))), 16'h1);
    rd(OFS_STATUS, d);
    chk("overflow flag", d & 16'h0001, 16'h0001);
    wr(OFS_STATUS, 16'h0001);
    rd(OFS_STATUS, d);
    chk("overflow clear", d & 16'h0001, 16'h0000);
    // Noise mode: no pin current, then pad activity
    wr(OFS_TB_CTRL, 16'h00C1);
    wr(OFS_CTRL0, 16'h00C0);
    repeat (8) @(posedge mclk);              // Let a rise already in the sync chain land
    wr(OFS_STATUS, 16'h0002);
    meas(OFS_TB_CNT, 320, d);
    chk("noise quiet", d, 16'h0000);
    rd(OFS_STATUS, d);
    chk("noise flag idle", d & 16'h0002, 16'h0000);
    @(posedge mclk) noise <= 1'b1;
    repeat (20) @(posedge mclk);
    rd(OFS_CTRL0, d);
    chk("dir sourcing", d & 16'h0002, 16'h0002);
    rd(OFS_STATUS, d);
    chk("noise flag", d & 16'h0002, 16'h0002);
    @(posedge mclk) noise <= 1'b0;
    repeat (20) @(posedge mclk);
    rd(OFS_CTRL0, d);
    chk("dir sinking", d & 16'h0002, 16'h0000);
    report_and_stop();
  end
endmodule : cs_range_timebase_bench
